// file: hpc_pkg.sv
// shared constants, state type and helpers for the host port controller
package hpc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing, clock 20 MHz
  localparam int CLK_NS       = 50;
  localparam int SMB_QTR_NS   = 2500;     // quarter of a 100 kHz bit
  localparam int SW_STRH_NS   = 40000;    // start low of a sent cell
  localparam int SW_DH_NS     = 150000;   // end of data hold, sent cell
  localparam int SW_DSU_NS    = 100000;   // sample point, received cell
  localparam int SW_CYC_NS    = 200000;   // whole cell
  localparam int SW_BRK_NS    = 200000;   // break low time
  localparam int SW_BR_NS     = 40000;    // break_recovery_time
  localparam int SW_TO_NS     = 250000;   // overlong cell
  localparam int EE_GUARD_NS  = 10000000; // wait before closing eeprom bridge
  localparam int SMB_QTR_CYC  = (SMB_QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int SW_STRH_CYC  = (SW_STRH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SW_DH_CYC    = (SW_DH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SW_DSU_CYC   = (SW_DSU_NS + CLK_NS - 1) / CLK_NS;
  localparam int SW_CYC_CYC   = (SW_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SW_BRK_CYC   = (SW_BRK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SW_BR_CYC    = (SW_BR_NS + CLK_NS - 1) / CLK_NS;
  localparam int SW_TO_CYC    = SW_TO_NS / CLK_NS;
  localparam int EE_GUARD_CYC = (EE_GUARD_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////
  // device map, reached over the serial bus
  localparam logic [6:0]  DEV_ADDR        = 7'h0B;
  localparam logic [7:0]  FACTORY_CMD_REG = 8'h00; // factory_command_word
  localparam logic [7:0]  LOW_CAP_REG     = 8'h01; // low_capacity_threshold
  localparam logic [15:0] FC_STORAGE      = 16'h0618;
  localparam logic [15:0] FC_LOCK         = 16'h062B;
  localparam logic [15:0] FC_SYNC         = 16'h064D;
  localparam logic [15:0] FC_CAL          = 16'h0653;
  localparam logic [15:0] FC_CAL_ALT      = 16'h067E;
  localparam logic [15:0] FC_CAL_STOP     = 16'h0660;
  localparam logic [15:0] FC_EE_BRIDGE    = 16'h0606;
  localparam logic [7:0]  CRC_POLY        = 8'h07;

  ////////////////////////////////////////////////////////////////////////
  // own registers
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_WDAT  = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_RDAT  = 8'h0C;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_RD    = 1;
  localparam int CTRL_PEC   = 2;
  localparam int CTRL_SW    = 3;
  localparam int CTRL_BRK   = 4;
  localparam int CTRL_GUARD = 5;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [6:0] {
    HPC_IDLE  = 7'h01,
    HPC_START = 7'h02,
    HPC_BIT   = 7'h04,
    HPC_STOP  = 7'h08,
    HPC_SWTX  = 7'h10,
    HPC_SWRX  = 7'h20,
    HPC_BRK   = 7'h40
  } hpc_st_t;

  typedef struct packed {
    hpc_st_t     st;
    logic [1:0]  q;
    logic [12:0] cnt;
    logic [4:0]  bitn;
    logic [2:0]  idx;
    logic [23:0] sh;
    logic [7:0]  crc;
    logic [15:0] rd;
    logic [15:0] ctrl;
    logic [15:0] wdat;
    logic [17:0] guard;
    logic        nack;
    logic        pec_err;
    logic        sw_err;
    logic        scl_oe;
    logic        sda_oe;
    logic        sw_oe;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [2:0]  sw_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } hpc_state_t;

  function automatic logic [7:0] hpc_crc_bit(input logic [7:0] c, input logic b);
    return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

endpackage

// file: hpc_host_port.sv
// host side controller: serial bus word master with packet check, single-wire port
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - no check byte: stop after last data
// - reads with check byte: ack last data, nack check byte
// - check byte is crc-8, poly x8+x2+x+1
// - check covers address, command, data bytes
// - command byte: 7-bit code, rw, 16 data
// - single-wire bits go least significant first
// - cell: pull low, data, release high
// - break low, then recovery high
// - calibration may follow storage command
// - serial bus only: wait 10 ms before closing eeprom bridge
// - device address 0001011 plus rw bit
module hpc_host_port
  import hpc_pkg::*;
#(
  parameter int SW_TO   = SW_TO_CYC,
  parameter int EE_WAIT = EE_GUARD_CYC
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // serial bus, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // single-wire port, open drain
  input  wire logic        sw_in,
  output logic             sw_out,
  output logic             sw_oe
);

  if (SW_TO < SW_CYC_CYC || SW_TO > 8191 || EE_WAIT < 1 || EE_WAIT > 262143)
  begin : g_chk
    $error("hpc_host_port: timeout parameters out of range");
  end

  hpc_state_t s;
  hpc_state_t n;
  logic       rd_m;
  logic       pec;
  logic [2:0] last;
  logic       tx;
  logic       qend;
  logic       aw_go;
  logic       sda;
  logic       sw_fall;
  logic [7:0] nxt_byte;

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign rd_m    = s.ctrl[CTRL_RD];
  assign pec     = s.ctrl[CTRL_PEC];
  assign last    = rd_m ? (pec ? 3'h5 : 3'h4) : (pec ? 3'h4 : 3'h3);
  assign tx      = !(rd_m && s.idx >= 3'h3);
  assign qend    = s.cnt == 13'(SMB_QTR_CYC - 1);
  assign sda     = s.sda_s[1];
  assign sw_fall = s.sw_s[2] && !s.sw_s[1];
  assign aw_go   = awvalid && wvalid && !s.bvalid;
  assign awready = aw_go;
  assign wready  = aw_go;
  assign arready = arvalid && !s.rvalid;

  // byte sent in slot idx+1; the check byte is the running crc
  always_comb
  begin
    unique case (s.idx)
      3'h0:    nxt_byte = s.ctrl[15:8];
      3'h1:    nxt_byte = rd_m ? {DEV_ADDR, 1'b1} : s.wdat[7:0];
      3'h2:    nxt_byte = s.wdat[15:8];
      default: nxt_byte = s.crc;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    n = s;
    n.scl_s = {s.scl_s[1:0], scl_in};
    n.sda_s = {s.sda_s[1:0], sda_in};
    n.sw_s  = {s.sw_s[1:0], sw_in};
    if (s.guard != 18'h0_0000)
      n.guard = s.guard - 18'h0_0001;
    if (s.bvalid && bready)
      n.bvalid = 1'b0;
    if (s.rvalid && rready)
      n.rvalid = 1'b0;
    // register reads
    if (arready)
    begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OK;
      unique case (araddr)
        REG_CTRL: n.rdata = {16'h0000, s.ctrl};
        REG_WDAT: n.rdata = {16'h0000, s.wdat};
        REG_STAT: n.rdata = {27'h000_0000, s.guard != 18'h0_0000, s.sw_err,
                             s.pec_err, s.nack, s.st != HPC_IDLE};
        REG_RDAT: n.rdata = {16'h0000, s.rd};
        default:
        begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_ERR;
        end
      endcase
    end
    // register writes; settings are frozen while a transfer runs
    if (aw_go)
    begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OK;
      if (awaddr == REG_CTRL && s.st == HPC_IDLE)
      begin
        if (wstrb[0])
          n.ctrl[7:1] = wdata[7:1];
        if (wstrb[1])
          n.ctrl[15:8] = wdata[15:8];
        if (wstrb[0] && wdata[CTRL_GO])
        begin
          n.nack    = 1'b0;
          n.pec_err = 1'b0;
          n.sw_err  = 1'b0;
          n.cnt     = 13'h0000;
          n.q       = 2'h0;
          n.bitn    = 5'h00;
          if (n.ctrl[CTRL_BRK])
            n.st = HPC_BRK;
          else if (n.ctrl[CTRL_SW])
          begin
            n.st = HPC_SWTX;
            n.sh = {s.wdat, n.ctrl[CTRL_RD], n.ctrl[14:8]};
          end
          else if (s.guard == 18'h0_0000)
          begin
            n.st  = HPC_START;
            n.q   = 2'h1;
            n.idx = 3'h0;
            n.crc = 8'h00;
            n.sh  = {16'h0000, DEV_ADDR, 1'b0};
          end
        end
      end
      else if (awaddr == REG_WDAT && s.st == HPC_IDLE)
      begin
        if (wstrb[0])
          n.wdat[7:0] = wdata[7:0];
        if (wstrb[1])
          n.wdat[15:8] = wdata[15:8];
      end
      else if (awaddr != REG_STAT && awaddr != REG_RDAT && awaddr != REG_CTRL
               && awaddr != REG_WDAT)
        n.bresp = RESP_ERR;
    end
    // transfer engine
    unique case (s.st)
      HPC_IDLE: ;
      HPC_START, HPC_STOP:
      begin
        n.cnt = s.cnt + 13'h0001;
        if (qend)
        begin
          n.cnt = 13'h0000;
          n.q   = s.q + 2'h1;
          if (s.q == 2'h3)
          begin
            n.bitn = 5'h00;
            n.st   = (s.st == HPC_START) ? HPC_BIT : HPC_IDLE;
            if (s.st == HPC_STOP && s.ctrl[CTRL_GUARD])
              n.guard = 18'(EE_WAIT);
          end
        end
      end
      HPC_BIT:
      begin
        n.cnt = s.cnt + 13'h0001;
        if (qend)
        begin
          n.cnt = 13'h0000;
          n.q   = s.q + 2'h1;
          if (s.q == 2'h2 && s.bitn < 5'h08)
          begin
            n.crc = hpc_crc_bit(s.crc, tx ? s.sh[7] : sda);
            if (!tx)
              n.sh[7:0] = {s.sh[6:0], sda};
          end
          else if (s.q == 2'h2 && tx && sda)
          begin
            if (!rd_m && pec && s.idx == 3'h4)
              n.pec_err = 1'b1;
            else
              n.nack = 1'b1;
          end
          else if (s.q == 2'h3 && s.bitn < 5'h08)
          begin
            n.bitn = s.bitn + 5'h01;
            if (tx)
              n.sh[7:0] = {s.sh[6:0], 1'b0};
          end
          else if (s.q == 2'h3)
          begin
            if (rd_m && s.idx == 3'h3)
              n.rd[7:0] = s.sh[7:0];
            if (rd_m && s.idx == 3'h4)
              n.rd[15:8] = s.sh[7:0];
            if (s.nack || s.pec_err || s.idx == last)
            begin
              n.st = HPC_STOP;
              if (rd_m && pec && s.idx == last && s.crc != 8'h00)
                n.pec_err = 1'b1;
            end
            else
            begin
              n.idx     = s.idx + 3'h1;
              n.bitn    = 5'h00;
              n.sh[7:0] = nxt_byte;
              if (rd_m && s.idx == 3'h1)
                n.st = HPC_START; // repeated start before the read address
            end
          end
        end
      end
      HPC_SWTX:
      begin
        n.cnt = s.cnt + 13'h0001;
        if (s.cnt == 13'(SW_CYC_CYC - 1))
        begin
          n.cnt  = 13'h0000;
          n.sh   = {1'b0, s.sh[23:1]};
          n.bitn = s.bitn + 5'h01;
          if (s.bitn == 5'h17)
            n.st = HPC_IDLE;
          else if (s.bitn == 5'h07 && rd_m)
          begin
            n.st = HPC_SWRX;
            n.q  = 2'h0;
          end
        end
      end
      HPC_SWRX:
      begin
        n.cnt = s.cnt + 13'h0001;
        if (!s.q[0] && sw_fall)
        begin
          n.q   = 2'h1;
          n.cnt = 13'h0000;
        end
        else if (!s.q[0] && s.cnt == 13'(SW_TO - 1))
        begin
          n.sw_err = 1'b1; // overlong cell, software sends a break next
          n.st     = HPC_IDLE;
        end
        else if (s.q[0] && s.cnt == 13'(SW_DSU_CYC - 1))
        begin
          n.rd   = {s.sw_s[1], s.rd[15:1]};
          n.bitn = s.bitn + 5'h01;
          n.q    = 2'h0;
          n.cnt  = 13'h0000;
          if (s.bitn == 5'h17)
            n.st = HPC_IDLE;
        end
      end
      HPC_BRK:
      begin
        n.cnt = s.cnt + 13'h0001;
        if (s.cnt == (s.q[0] ? 13'(SW_BR_CYC - 1) : 13'(SW_BRK_CYC - 1)))
        begin
          n.cnt = 13'h0000;
          n.q   = 2'h1;
          if (s.q[0])
            n.st = HPC_IDLE;
        end
      end
      default:
        n.st = HPC_IDLE;
    endcase
    // pin drive follows the next state so that it is registered
    n.scl_oe = (n.st == HPC_START && (n.q == 2'h0 || n.q == 2'h3))
             || ((n.st == HPC_BIT || n.st == HPC_STOP) && n.q < 2'h2);
    unique case (n.st)
      HPC_START: n.sda_oe = n.q >= 2'h2;
      HPC_STOP:  n.sda_oe = n.q == 2'h1 || n.q == 2'h2;
      // direction from the next index inline; a net fed back from n would loop
      HPC_BIT:   n.sda_oe = (n.bitn < 5'h08) ? (!(rd_m && n.idx >= 3'h3) && !n.sh[7])
                           : (rd_m && n.idx >= 3'h3 && n.idx != last);
      default:   n.sda_oe = 1'b0;
    endcase
    n.sw_oe = (n.st == HPC_BRK && !n.q[0])
            || (n.st == HPC_SWTX && (n.cnt < 13'(SW_STRH_CYC)
                || (n.cnt < 13'(SW_DH_CYC) && !n.sh[0])));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s      <= '0;
      s.st   <= HPC_IDLE;
      s.scl_s <= 3'h7;
      s.sda_s <= 3'h7;
      s.sw_s  <= 3'h7;
    end
    else
      s <= n;
  end

  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign rvalid  = s.rvalid;
  assign rresp   = s.rresp;
  assign rdata   = s.rdata;
  assign scl_oe  = s.scl_oe;
  assign sda_oe  = s.sda_oe;
  assign sw_oe   = s.sw_oe;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign sw_out  = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_no_pec_stop: assert property (
    s.st == HPC_BIT && s.q == 2'h3 && qend && s.bitn == 5'h08 && !rd_m && !pec
    && s.idx == 3'h3 |=> s.st == HPC_STOP) else $error("no stop after last data");
  chk_ack_data: assert property (
    s.st == HPC_BIT && rd_m && pec && s.idx == 3'h4 && s.bitn == 5'h08 && s.q == 2'h2
    |-> s.sda_oe) else $error("last data byte not acked");
  chk_nack_pec: assert property (
    s.st == HPC_BIT && rd_m && s.idx == last && s.bitn == 5'h08 && s.q == 2'h2
    |-> !s.sda_oe) else $error("final read byte not nacked");
  chk_pec_value: assert property (
    s.st == HPC_BIT && !rd_m && s.idx == 3'h4 && s.bitn == 5'h00 && s.q == 2'h0
    && s.cnt == 13'h0000 |-> s.sh[7:0] == s.crc) else $error("check byte wrong");
  chk_crc_clear: assert property (
    $rose(s.st == HPC_START) && s.idx == 3'h0 |-> s.crc == 8'h00)
    else $error("check register not cleared");
  chk_addr_byte: assert property (
    $rose(s.st == HPC_BIT) && s.idx == 3'h0 |-> s.sh[7:0] == {DEV_ADDR, 1'b0})
    else $error("bad address byte");
  chk_sw_cmd: assert property (
    $rose(s.st == HPC_SWTX) |-> s.sh[7] == rd_m && s.sh[6:0] == s.ctrl[14:8])
    else $error("bad command byte");
  chk_sw_cell: assert property (
    s.st == HPC_SWTX && s.cnt == 13'h0001 |-> s.sw_oe ##1 s.sw_oe)
    else $error("cell does not start low");
  chk_break_low: assert property (
    $rose(s.st == HPC_BRK) |-> s.sw_oe [*8]) else $error("break not held low");
  chk_stop_seq: assert property (
    $rose(s.st == HPC_STOP) |-> s.scl_oe && !s.sda_oe) else $error("stop opens badly");

  cov_write: cover property ($fell(s.st == HPC_STOP) && !rd_m && pec);
  cov_read: cover property ($fell(s.st == HPC_STOP) && rd_m && !s.pec_err);
  cov_sw: cover property ($fell(s.st == HPC_SWRX));
  cov_brk: cover property ($fell(s.st == HPC_BRK));

endmodule

`default_nettype wire

// file: hpc_dev_model.sv
// behavioural gas gauge: serial bus slave with check byte, single-wire slave
`timescale 1ns/1ps
`default_nettype none

module hpc_dev_model
  import hpc_pkg::*;
(
  // pins, levels worked out by the bench
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic sw_in,
  output var  logic dev_sda_oe,
  output var  logic dev_sw_oe,
  // commanded faults and pace
  input  wire logic bad_pec,
  input  wire logic sw_mute,
  input  wire logic slow
);
  logic [15:0] regs [128] = '{default: 16'h0000};
  logic        pec_fault  = 1'b0;
  time         t_fall     = 0;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)  // msb first
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial bus slave; #1 lets both lines settle after an edge
  task automatic rx_bit(output logic v, output logic c);
    @(posedge scl_in);
    v = sda_in;
    @(negedge scl_in or sda_in);
    #1;
    c = scl_in;
  endtask

  task automatic rx_byte(output logic [7:0] b, output logic c);
    logic v;
    for (int i = 7; i >= 0; i--)
    begin
      rx_bit(v, c);
      b[i] = v;
      if (c)
        return;
    end
  endtask

  task automatic ack(input logic a);
    dev_sda_oe = a;
    @(posedge scl_in);
    @(negedge scl_in);
    #1;
    dev_sda_oe = 1'b0;
  endtask

  task automatic tx_byte(input logic [7:0] b, output logic k);
    for (int i = 7; i >= 0; i--)
    begin
      dev_sda_oe = !b[i];
      @(posedge scl_in);
      @(negedge scl_in);
      #1;
    end
    dev_sda_oe = 1'b0;
    @(posedge scl_in);
    k = !sda_in;
    @(negedge scl_in);
    #1;
  endtask

  task automatic frame();
    logic [7:0] a, cm, lo, hi, pc, crc;
    logic       c, k;
    rx_byte(a, c);
    if (c || a !== {DEV_ADDR, 1'b0})  // own address only, no broadcasts mastered
      return;
    ack(1'b1);
    rx_byte(cm, c);
    ack(1'b1);
    crc = crc8(crc8(8'h00, a), cm);  // zero start, every byte
    rx_byte(lo, c);
    if (c)
    begin
      rx_byte(a, c);
      ack(1'b1);
      {hi, lo} = regs[cm[6:0]];
      crc = crc8(crc8(crc8(crc, a), lo), hi);
      tx_byte(lo, k);
      if (k)
        tx_byte(hi, k);
      if (k)  // check byte only after acked last data
        tx_byte(crc ^ {7'h00, bad_pec}, k);
      return;
    end
    ack(1'b1);
    rx_byte(hi, c);
    ack(1'b1);
    crc = crc8(crc8(crc, lo), hi);
    rx_byte(pc, c);
    k = 1'b1;
    if (!c)  // compare, nack and note a bad check byte
    begin
      k = (pc === crc) && !bad_pec;
      pec_fault = !k;
      ack(k);
    end
    if (k)  // stop after data is complete, taken any time
      regs[cm[6:0]] = {hi, lo};
  endtask

  initial
  begin
    dev_sda_oe = 1'b0;
    forever
    begin
      @(negedge sda_in iff scl_in === 1'b1);
      #1;
      frame();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single-wire slave
  task automatic rx_cell(output logic v, output logic brk);
    @(negedge sw_in);
    t_fall = $time;
    @(posedge sw_in);
    brk = ($time - t_fall) >= SW_BRK_NS;
    v = ($time - t_fall) < SW_DSU_NS;  // level at the set point
  endtask

  task automatic sw_rx(input int n, output logic [15:0] d, output logic brk);
    logic v;
    d = 16'h0000;
    for (int i = 0; i < n; i++)
    begin
      rx_cell(v, brk);
      if (brk)
        return;
      d[i] = v;
    end
  endtask

  task automatic sw_tx(input logic [15:0] d);
    #(t_fall + SW_CYC_NS + (slow ? 40000 : 5000) - $time);
    for (int i = 0; i < 16; i++)
    begin
      dev_sw_oe = 1'b1;
      #(d[i] ? SW_STRH_NS : SW_DH_NS);
      dev_sw_oe = 1'b0;
      #(d[i] ? SW_CYC_NS - SW_STRH_NS : SW_CYC_NS - SW_DH_NS);
    end
  endtask

  initial
  begin
    logic [15:0] cmd, d;
    logic        brk;
    dev_sw_oe = 1'b0;
    forever
    begin
      sw_rx(8, cmd, brk);
      if (brk)
        #(SW_BR_NS);
      else if (cmd[7] && !sw_mute)
        sw_tx(regs[cmd[6:0]]);
      else if (!cmd[7])
      begin
        sw_rx(16, d, brk);
        if (!brk)
          regs[cmd[6:0]] = d;
      end
    end
  end
endmodule

`default_nettype wire

// file: testbench.sv
// testbench: host port controller against the behavioural gas gauge
`timescale 1ns/1ps
`default_nettype none

module testbench
  import hpc_pkg::*;
;
  localparam logic [7:0] F_RD  = 8'h02;
  localparam logic [7:0] F_PEC = 8'h04;
  localparam logic [7:0] F_SW  = 8'h08;
  localparam logic [7:0] F_BRK = 8'h10;
  localparam logic [7:0] F_GRD = 8'h20;

  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, bad_pec, sw_mute, slow;
  logic        scl_out, scl_oe, sda_out, sda_oe, sw_out, sw_oe, dev_sda_oe, dev_sw_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, rs;
  wire         scl_in, sda_in, sw_in;
  int          errors, comparisons;

  // open drain with pull-ups
  assign scl_in = !scl_oe;
  assign sda_in = !(sda_oe | dev_sda_oe);
  assign sw_in  = !(sw_oe | dev_sw_oe);

  hpc_host_port #(.EE_WAIT(40)) hpc_host_port_inst (.clk, .rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .sw_in, .sw_out, .sw_oe);

  hpc_dev_model hpc_dev_model_inst (.scl_in, .sda_in, .sw_in, .dev_sda_oe, .dev_sw_oe,
    .bad_pec, .sw_mute, .slow);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready  <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    rready  <= 1'b0;
  endtask

  // go, then poll busy; the watchdog ends a hang
  task automatic op(input logic [7:0] cmd, input logic [7:0] fl, input logic [15:0] d);
    axw(REG_WDAT, {16'h0000, d});
    axw(REG_CTRL, {16'h0000, cmd, fl | 8'h01});
    do axr(REG_STAT); while (rv[0] !== 1'b0);
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    axr(REG_STAT);
    chk(rv & m, e);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    st(32'hffff_ffff, 32'h0000_0000);
    chk({26'h0, scl_oe, sda_oe, sw_oe, scl_out, sda_out, sw_out}, 32'h0000_0000);
    axr(8'h10);
    chk({rv[29:0], rs}, {30'h0, RESP_ERR});
    axw(8'h10, 32'h0000_ffff);
    chk({30'h0, rs}, {30'h0, RESP_ERR});
  endtask

  task automatic t_pec();
    op(LOW_CAP_REG, F_PEC, 16'habcd);
    st(32'h0000_0007, 32'h0000_0000);
    chk({16'h0, hpc_dev_model_inst.regs[1]}, 32'h0000_abcd);
    op(LOW_CAP_REG, F_PEC | F_RD, 16'h0000);
    st(32'h0000_0007, 32'h0000_0000);
    axr(REG_RDAT);
    chk(rv, 32'h0000_abcd);
    op(LOW_CAP_REG, F_RD, 16'h0000);
    axr(REG_RDAT);
    chk(rv, 32'h0000_abcd);
  endtask

  task automatic t_bad();
    bad_pec <= 1'b1;
    op(LOW_CAP_REG, F_PEC | F_RD, 16'h0000);
    st(32'h0000_0004, 32'h0000_0004);
    op(LOW_CAP_REG, F_PEC, 16'h1111);
    st(32'h0000_0004, 32'h0000_0004);
    chk({16'h0, hpc_dev_model_inst.regs[1]}, 32'h0000_abcd);
    bad_pec <= 1'b0;
  endtask

  task automatic t_factory();
    logic [15:0] codes [7];
    codes = '{FC_STORAGE, FC_LOCK, FC_SYNC, FC_CAL, FC_CAL_ALT, FC_CAL_STOP, FC_EE_BRIDGE};
    foreach (codes[i])
    begin
      op(FACTORY_CMD_REG, 8'h00, codes[i]);
      chk({16'h0, hpc_dev_model_inst.regs[0]}, {16'h0, codes[i]});
    end
  endtask

  // bridge closing address held back by the guard
  task automatic t_guard();
    op(FACTORY_CMD_REG, F_GRD, FC_EE_BRIDGE);
    st(32'h0000_0011, 32'h0000_0010);
    op(LOW_CAP_REG, 8'h00, 16'h2222);
    st(32'h0000_0011, 32'h0000_0010);
    chk({16'h0, hpc_dev_model_inst.regs[1]}, 32'h0000_abcd);
    repeat (60) @(posedge clk);
    st(32'h0000_0011, 32'h0000_0000);
  endtask

  // code 0 with read flag is not a palindrome, so bit order shows
  task automatic t_sw();
    sw_mute <= 1'b1;
    op(8'h01, F_SW | F_RD, 16'h0000);
    st(32'h0000_0009, 32'h0000_0008);
    sw_mute <= 1'b0;
    op(8'h00, F_BRK, 16'h0000);
    st(32'h0000_000f, 32'h0000_0000);
    slow <= 1'b1;
    op(8'h00, F_SW | F_RD, 16'h0000);
    st(32'h0000_0008, 32'h0000_0000);
    axr(REG_RDAT);
    chk(rv, {16'h0000, FC_EE_BRIDGE});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #(30_000_000);
    errors++;
    wrap_up();
  end

  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b10_0000;
    {bad_pec, sw_mute, slow} = 3'b000;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_pec();
    t_bad();
    t_factory();
    t_guard();
    t_sw();
    wrap_up();
  end
endmodule

`default_nettype wire
